// >>> verilog/srx_exec.sv
// Execution unit for returns, rotates, shifts, flag load and borrow subtract
// Assumes operands, stack words and pop value are staged by software over AXI4-Lite
// Operation
// - Return loads IP from stack, SP plus two
// - Far return also pops code segment, SP plus two
// - Pop value added to SP after pops
// - C3 near return, C2 near with pop value
// - CB far return, CA far with pop value
// - Count one if v clear, else count register
// - Rotate left through top bit, CF OF only
// - Rotate right, OF from two top bits
// - Left shift fills zero, OF top versus CF
// - Shifts update CF OF PF SF ZF
// - Arithmetic right shift refills with sign bit
// - Flag load copies accumulator high bits
// - Borrow subtract minus one when CF set
// - Borrow subtract updates six arithmetic flags
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module srx_exec
   import srx_pkg::*;
(
   input  wire logic              aclk,     // Core clock
   input  wire logic              aresetn,  // Sync reset, low
   input  wire logic [ADDR_W-1:0] awaddr,   // Write address
   input  wire logic              awvalid,  // Write address valid
   output logic                   awready,  // Write address ready
   input  wire logic [31:0]       wdata,    // Write data
   input  wire logic [3:0]        wstrb,    // Byte enables
   input  wire logic              wvalid,   // Write data valid
   output logic                   wready,   // Write data ready
   output logic [1:0]             bresp,    // Write response
   output logic                   bvalid,   // Write response valid
   input  wire logic              bready,   // Write response ready
   input  wire logic [ADDR_W-1:0] araddr,   // Read address
   input  wire logic              arvalid,  // Read address valid
   output logic                   arready,  // Read address ready
   output logic [31:0]            rdata,    // Read data
   output logic [1:0]             rresp,    // Read response
   output logic                   rvalid,   // Read data valid
   input  wire logic              rready    // Read data ready
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   srx_cmd_s    cmd_q;
   logic        exec_q, bad_q, bad_d;
   logic [15:0] opa_q, opb_q, flags_q, sp_q, ip_q, cs_q;
   logic [15:0] stk0_q, stk1_q, imm_q, res_q, f_d, r_d, sp_d;
   logic [7:0]  cnt_q, acch_q, n;
   logic        wr_hs, rd_hs, wmap, rmap;
   logic [31:0] rd_d;

   // Byte lane merge
   function automatic logic [15:0] m16(logic [15:0] o, logic [31:0] d, logic [3:0] s);
      return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
   endfunction : m16

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   // Address and data taken together, one write in flight
   assign wr_hs   = awvalid && wvalid && !bvalid;
   assign awready = wr_hs;
   assign wready  = wr_hs;
   assign rd_hs   = arvalid && !rvalid;
   assign arready = !rvalid;
   assign wmap    = awaddr inside {ADR_CMD, ADR_OPA, ADR_OPB, ADR_CNT, ADR_FLG, ADR_SP,
                                   ADR_STK0, ADR_STK1, ADR_IMM, ADR_ACCH};
   assign rmap    = araddr inside {ADR_CMD, ADR_OPA, ADR_OPB, ADR_CNT, ADR_FLG, ADR_SP, ADR_IP,
                                   ADR_CS, ADR_STK0, ADR_STK1, ADR_IMM, ADR_ACCH, ADR_RES, ADR_STAT};

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OK;
      end else if (wr_hs) begin
         bvalid <= 1'b1;
         bresp  <= wmap ? RESP_OK : RESP_ERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // Read data mux
   always_comb begin
      rd_d = 32'h0000_0000;
      case (araddr)
         ADR_CMD:  rd_d = {14'h0000, cmd_q.subtract_with_borrow, cmd_q.wide, 5'h00, cmd_q.regf, cmd_q.opcode};
         ADR_OPA:  rd_d[15:0] = opa_q;
         ADR_OPB:  rd_d[15:0] = opb_q;
         ADR_CNT:  rd_d[7:0]  = cnt_q;
         ADR_FLG:  rd_d[15:0] = flags_q;
         ADR_SP:   rd_d[15:0] = sp_q;
         ADR_IP:   rd_d[15:0] = ip_q;
         ADR_CS:   rd_d[15:0] = cs_q;
         ADR_STK0: rd_d[15:0] = stk0_q;
         ADR_STK1: rd_d[15:0] = stk1_q;
         ADR_IMM:  rd_d[15:0] = imm_q;
         ADR_ACCH: rd_d[7:0]  = acch_q;
         ADR_RES:  rd_d[15:0] = res_q;
         ADR_STAT: rd_d[0]    = bad_q;
         default:  rd_d = 32'h0000_0000;
      endcase
   end

   // Read response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= RESP_OK;
      end else if (rd_hs) begin
         rvalid <= 1'b1;
         rdata  <= rd_d;
         rresp  <= rmap ? RESP_OK : RESP_ERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // Software staged operands and command
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_q <= '0;
         opa_q <= RST_16;
         opb_q <= RST_16;
         cnt_q <= 8'h00;
         stk0_q <= RST_16;
         stk1_q <= RST_16;
         imm_q <= RST_16;
         acch_q <= 8'h00;
      end else if (wr_hs) begin
         case (awaddr)
            ADR_CMD:  cmd_q <= {wdata[CMD_SBB], wdata[CMD_WIDE], wdata[10:8], wdata[7:0]};
            ADR_OPA:  opa_q <= m16(opa_q, wdata, wstrb);
            ADR_OPB:  opb_q <= m16(opb_q, wdata, wstrb);
            ADR_CNT:  cnt_q <= wstrb[0] ? wdata[7:0] : cnt_q;
            ADR_STK0: stk0_q <= m16(stk0_q, wdata, wstrb);
            ADR_STK1: stk1_q <= m16(stk1_q, wdata, wstrb);
            ADR_IMM:  imm_q <= m16(imm_q, wdata, wstrb); // Low and high bytes written together, each under its own byte enable
            ADR_ACCH: acch_q <= wstrb[0] ? wdata[7:0] : acch_q;
            default:  ;
         endcase
      end
   end

   // Command write starts one execution cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) exec_q <= 1'b0;
      else exec_q <= wr_hs && (awaddr == ADR_CMD);
   end

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic is_rn, is_rni, is_rf, is_rfi, is_ret, is_fld, is_sh, w, top, nxt;
   assign is_rn  = !cmd_q.subtract_with_borrow && cmd_q.opcode == OPC_RN;
   assign is_rni = !cmd_q.subtract_with_borrow && cmd_q.opcode == OPC_RNI;
   assign is_rf  = !cmd_q.subtract_with_borrow && cmd_q.opcode == OPC_RF;
   assign is_rfi = !cmd_q.subtract_with_borrow && cmd_q.opcode == OPC_RFI;
   assign is_ret = is_rn || is_rni || is_rf || is_rfi;
   assign is_fld = !cmd_q.subtract_with_borrow && cmd_q.opcode == OPC_FLD;
   assign is_sh  = !cmd_q.subtract_with_borrow && cmd_q.opcode[7:2] == OPC_SHG;
   assign w      = cmd_q.subtract_with_borrow ? cmd_q.wide : cmd_q.opcode[0];
   assign n      = cmd_q.opcode[1] ? cnt_q : CNT_ONE;

   // ----------------------------------------
   // Shift and rotate datapath
   // ----------------------------------------
   logic [15:0] x, rot_l, rot_r;
   logic [16:0] shl_e, sar_e;
   logic [31:0] rl32, rr32;
   logic [15:0] rl16, rr16;
   logic [3:0]  k;
   // Byte operands are left justified so one 16-bit shifter serves both sizes
   assign x     = w ? opa_q : {opa_q[7:0], 8'h00};
   assign shl_e = 17'({1'b0, x} << n);
   assign sar_e = 17'($signed({x, 1'b0}) >>> n);
   assign k     = w ? n[3:0] : {1'b0, n[2:0]};
   assign rl32  = {opa_q, opa_q} << k;
   assign rr32  = {opa_q, opa_q} >> k;
   assign rl16  = {opa_q[7:0], opa_q[7:0]} << k[2:0];
   assign rr16  = {opa_q[7:0], opa_q[7:0]} >> k[2:0];
   assign rot_l = w ? rl32[31:16] : {8'h00, rl16[15:8]};
   assign rot_r = w ? rr32[15:0] : {8'h00, rr16[7:0]};

   // ----------------------------------------
   // Borrow subtract datapath
   // ----------------------------------------
   logic [16:0] sw;
   logic [8:0]  sb;
   logic [4:0]  sn;
   logic        cin;
   assign cin = flags_q[F_CF];
   assign sw  = {1'b0, opa_q} - {1'b0, opb_q} - {16'h0000, cin};
   assign sb  = {1'b0, opa_q[7:0]} - {1'b0, opb_q[7:0]} - {8'h00, cin};
   assign sn  = {1'b0, opa_q[3:0]} - {1'b0, opb_q[3:0]} - {4'h0, cin};

   // Result, flags and stack pointer next values
   always_comb begin
      f_d   = flags_q;
      r_d   = res_q;
      sp_d  = sp_q;
      bad_d = 1'b0;
      if (is_ret) begin
         sp_d = sp_q + SP_STEP;
         if (is_rf || is_rfi) sp_d = sp_d + SP_STEP;
         if (is_rni || is_rfi) sp_d = sp_d + imm_q;
      end else if (is_fld) begin
         f_d = (flags_q & ~LOAD_MSK) | ({8'h00, acch_q} & LOAD_MSK);
      end else if (cmd_q.subtract_with_borrow) begin
         r_d = w ? sw[15:0] : {8'h00, sb[7:0]};
         f_d[F_CF] = w ? sw[16] : sb[8];
         f_d[F_AF] = sn[4];
         f_d[F_OF] = w ? (opa_q[15] != opb_q[15]) && (sw[15] != opa_q[15])
                       : (opa_q[7] != opb_q[7]) && (sb[7] != opa_q[7]);
      end else if (is_sh) begin
         case (cmd_q.regf)
            RF_ROL:  r_d = rot_l;
            RF_ROR:  r_d = rot_r;
            RF_SHL:  r_d = w ? shl_e[15:0] : {8'h00, shl_e[15:8]};
            RF_SAR:  r_d = w ? sar_e[16:1] : {8'h00, sar_e[16:9]};
            default: bad_d = 1'b1;
         endcase
      end else begin
         bad_d = 1'b1;
      end
      top = w ? r_d[15] : r_d[7];
      nxt = w ? r_d[14] : r_d[6];
      // Zero count leaves every flag as it was
      if (is_sh && !bad_d && n != 8'h00) begin
         case (cmd_q.regf)
            RF_ROL: begin
               f_d[F_CF] = r_d[0];
               if (n == CNT_ONE) f_d[F_OF] = top != r_d[0];
            end
            RF_ROR: begin
               f_d[F_CF] = top;
               if (n == CNT_ONE) f_d[F_OF] = top != nxt;
            end
            RF_SHL: begin
               f_d[F_CF] = shl_e[16];
               if (n == CNT_ONE) f_d[F_OF] = top != shl_e[16];
            end
            default: begin
               f_d[F_CF] = w ? sar_e[0] : sar_e[8];
               f_d[F_OF] = (n == CNT_ONE) && (top != nxt);
            end
         endcase
      end
      // Arithmetic flags from result, auxiliary carry kept for shifts
      // Borrow subtract always updates, shifts only with a nonzero count
      if (cmd_q.subtract_with_borrow || (is_sh && !bad_d && cmd_q.regf inside {RF_SHL, RF_SAR} && n != 8'h00)) begin
         f_d[F_ZF] = w ? (r_d == 16'h0000) : (r_d[7:0] == 8'h00);
         f_d[F_SF] = top;
         f_d[F_PF] = ~^r_d[7:0];
      end
   end

   // ----------------------------------------
   // Architectural state
   // ----------------------------------------
   // Flags: executed update or software write
   always_ff @(posedge aclk) begin
      if (!aresetn) flags_q <= RST_16;
      else if (exec_q) flags_q <= f_d;
      else if (wr_hs && awaddr == ADR_FLG) flags_q <= m16(flags_q, wdata, wstrb);
   end

   // Stack pointer
   always_ff @(posedge aclk) begin
      if (!aresetn) sp_q <= RST_16;
      else if (exec_q) sp_q <= sp_d;
      else if (wr_hs && awaddr == ADR_SP) sp_q <= m16(sp_q, wdata, wstrb);
   end

   // Instruction pointer, code segment, result and error status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ip_q  <= RST_16;
         cs_q  <= RST_16;
         res_q <= RST_16;
         bad_q <= 1'b0;
      end else if (exec_q) begin
         if (is_ret) ip_q <= stk0_q;
         if (is_rf || is_rfi) cs_q <= stk1_q;
         res_q <= r_d;
         bad_q <= bad_d;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_ret_exec;
      exec_q && is_ret;
   endsequence
   sequence s_cmd_wr;
      wr_hs && awaddr == ADR_CMD;
   endsequence
   property p_ret_ip;
      @(posedge aclk) disable iff (!aresetn) s_ret_exec |=> ip_q == $past(stk0_q);
   endproperty
   a_ret_ip: assert property (p_ret_ip) else $error("return ip wrong");
   property p_far_sp;
      @(posedge aclk) disable iff (!aresetn)
         s_ret_exec and is_rf |=> cs_q == $past(stk1_q) && sp_q == $past(sp_q) + 16'h0004;
   endproperty
   a_far_sp: assert property (p_far_sp) else $error("far return pop wrong");
   property p_imm_sp;
      @(posedge aclk) disable iff (!aresetn)
         s_ret_exec and is_rni |=> sp_q == $past(sp_q) + SP_STEP + $past(imm_q);
   endproperty
   a_imm_sp: assert property (p_imm_sp) else $error("pop value not added");
   property p_near_sp;
      @(posedge aclk) disable iff (!aresetn) s_ret_exec and is_rn |=> sp_q == $past(sp_q) + SP_STEP;
   endproperty
   a_near_sp: assert property (p_near_sp) else $error("near return sp wrong");
   property p_ret_flags;
      @(posedge aclk) disable iff (!aresetn) s_cmd_wr ##1 s_ret_exec |=> $stable(flags_q);
   endproperty
   a_ret_flags: assert property (p_ret_flags) else $error("return changed flags");
   property p_rol1;
      @(posedge aclk) disable iff (!aresetn)
         exec_q && is_sh && cmd_q.regf == RF_ROL && cmd_q.opcode[1:0] == 2'b01
         |=> res_q == {$past(opa_q[14:0]), $past(opa_q[15])} && flags_q[F_CF] == $past(opa_q[15]);
   endproperty
   a_rol1: assert property (p_rol1) else $error("rotate left wrong");
   property p_ror1;
      @(posedge aclk) disable iff (!aresetn)
         exec_q && is_sh && cmd_q.regf == RF_ROR && cmd_q.opcode[1:0] == 2'b01
         |=> flags_q[F_OF] == (res_q[15] != res_q[14]) && flags_q[F_CF] == $past(opa_q[0]);
   endproperty
   a_ror1: assert property (p_ror1) else $error("rotate right wrong");
   property p_shl_byte;
      @(posedge aclk) disable iff (!aresetn)
         exec_q && is_sh && cmd_q.regf == RF_SHL && cmd_q.opcode[1:0] == 2'b00
         |=> res_q == {8'h00, $past(opa_q[6:0]), 1'b0} && flags_q[F_CF] == $past(opa_q[7]);
   endproperty
   a_shl_byte: assert property (p_shl_byte) else $error("byte left shift wrong");
   property p_sar_of;
      @(posedge aclk) disable iff (!aresetn)
         exec_q && is_sh && cmd_q.regf == RF_SAR && cmd_q.opcode[1] && cnt_q > CNT_ONE
         |=> !flags_q[F_OF] && res_q[15] == $past(opa_q[15]) | !$past(w);
   endproperty
   a_sar_of: assert property (p_sar_of) else $error("sar overflow not cleared");
   property p_fld;
      @(posedge aclk) disable iff (!aresetn)
         exec_q && is_fld |=> flags_q[F_SF] == $past(acch_q[7]) && flags_q[F_CF] == $past(acch_q[0])
            && flags_q[F_OF] == $past(flags_q[F_OF]);
   endproperty
   a_fld: assert property (p_fld) else $error("flag load wrong");
   property p_sbb;
      @(posedge aclk) disable iff (!aresetn)
         exec_q && cmd_q.subtract_with_borrow && cmd_q.wide
         |=> res_q == 16'($past(opa_q) - $past(opb_q) - {15'h0000, $past(flags_q[F_CF])})
            && flags_q[F_ZF] == (res_q == 16'h0000);
   endproperty
   a_sbb: assert property (p_sbb) else $error("borrow subtract wrong");
endmodule : srx_exec

// >>> verilog/srx_pkg.sv
// Constants and types for the shift, rotate and return execution block
// Assumes a 32-bit AXI4-Lite register bus with byte addresses
package srx_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int           ADDR_W   = 8;
   localparam logic [7:0]   ADR_CMD  = 8'h00;
   localparam logic [7:0]   ADR_OPA  = 8'h04;
   localparam logic [7:0]   ADR_OPB  = 8'h08;
   localparam logic [7:0]   ADR_CNT  = 8'h0C;
   localparam logic [7:0]   ADR_FLG  = 8'h10;
   localparam logic [7:0]   ADR_SP   = 8'h14;
   localparam logic [7:0]   ADR_IP   = 8'h18;
   localparam logic [7:0]   ADR_CS   = 8'h1C;
   localparam logic [7:0]   ADR_STK0 = 8'h20;
   localparam logic [7:0]   ADR_STK1 = 8'h24;
   localparam logic [7:0]   ADR_IMM  = 8'h28;
   localparam logic [7:0]   ADR_ACCH = 8'h2C;
   localparam logic [7:0]   ADR_RES  = 8'h30;
   localparam logic [7:0]   ADR_STAT = 8'h34;
   localparam int           CMD_WIDE = 16;
   localparam int           CMD_SBB  = 17;
   localparam logic [15:0]  RST_16   = 16'h0000;
   localparam logic [1:0]   RESP_OK  = 2'h0;
   localparam logic [1:0]   RESP_ERR = 2'h2;
   // ----------------------------------------
   // Flag word layout
   // ----------------------------------------
   localparam int           F_CF     = 0;
   localparam int           F_PF     = 2;
   localparam int           F_AF     = 4;
   localparam int           F_ZF     = 6;
   localparam int           F_SF     = 7;
   localparam int           F_OF     = 11;
   localparam logic [15:0]  LOAD_MSK = 16'h00D5;
   // ----------------------------------------
   // Opcodes and steps
   // ----------------------------------------
   localparam logic [7:0]   OPC_RN   = 8'hC3;
   localparam logic [7:0]   OPC_RNI  = 8'hC2;
   localparam logic [7:0]   OPC_RF   = 8'hCB;
   localparam logic [7:0]   OPC_RFI  = 8'hCA;
   localparam logic [7:0]   OPC_FLD  = 8'h9E;
   localparam logic [5:0]   OPC_SHG  = 6'h34;
   localparam logic [2:0]   RF_ROL   = 3'h0;
   localparam logic [2:0]   RF_ROR   = 3'h1;
   localparam logic [2:0]   RF_SHL   = 3'h4;
   localparam logic [2:0]   RF_SAR   = 3'h7;
   localparam logic [15:0]  SP_STEP  = 16'h0002;
   localparam logic [7:0]   CNT_ONE  = 8'h01;
   // Latched command word
   typedef struct packed {
      logic       subtract_with_borrow;
      logic       wide;
      logic [2:0] regf;
      logic [7:0] opcode;
   } srx_cmd_s;
endpackage : srx_pkg

// >>> sim/srx_testbench.sv
// Self-checking bench for the shift, rotate, return and borrow subtract unit
// Assumes srx_pkg and srx_exec are compiled first; bench is the AXI4-Lite master
`timescale 1ns/1ps
`define check_eq(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; $display("BAD %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module testbench;
   import srx_pkg::*;
   // ----------------------------------------
   // Signals and bench state
   // ----------------------------------------
   localparam logic [15:0] FMSK = 16'h08D5;
   logic              aclk    = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr  = '0;
   logic              awvalid = 1'b0;
   logic              awready;
   logic [31:0]       wdata   = '0;
   logic [3:0]        wstrb   = 4'hF;
   logic              wvalid  = 1'b0;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready  = 1'b0;
   logic [ADDR_W-1:0] araddr  = '0;
   logic              arvalid = 1'b0;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready  = 1'b0;
   logic [1:0]        wr_resp;
   logic [31:0]       rd_data;
   logic [1:0]        rd_resp;
   int                err_count       = 0;
   int                samples_checked = 0;

   srx_exec u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));

   // Core clock, 40 ns period
   always #20 aclk = ~aclk;

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   // Write: address and data offered together, response taken under bready
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      @(negedge aclk);
      while (!(awready && wready) && n < 50) begin
         @(negedge aclk);
         n++;
      end
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      @(negedge aclk);
      while (!bvalid && n < 100) begin
         @(negedge aclk);
         n++;
      end
      wr_resp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr

   // Read: address held until arready, data taken under rready
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      @(negedge aclk);
      while (!arready && n < 50) begin
         @(negedge aclk);
         n++;
      end
      @(posedge aclk);
      arvalid <= 1'b0;
      @(negedge aclk);
      while (!rvalid && n < 100) begin
         @(negedge aclk);
         n++;
      end
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd

   // Verdict and end of run
   task automatic report_and_stop;
      if (err_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // ----------------------------------------
   // Expectation functions
   // ----------------------------------------
   // Shift group: returns {flags, result}
   function automatic logic [31:0] shift_ref(input logic [7:0] opc, input logic [2:0] rf,
                                             input logic [15:0] a, input logic [7:0] c, input logic [15:0] f);
      logic [15:0] r, m, fo;
      logic        cf, top;
      int          n, w;
      w  = opc[0] ? 16 : 8;
      m  = opc[0] ? 16'hFFFF : 16'h00FF;
      n  = opc[1] ? int'(c) : 1;
      r  = a & m;
      cf = f[F_CF];
      fo = f;
      for (int i = 0; i < n; i++) begin
         top = r[w-1];
         cf  = (rf == RF_ROL || rf == RF_SHL) ? top : r[0];
         r   = (rf == RF_ROL || rf == RF_SHL) ? ((r << 1) & m) : (r >> 1);
         if (rf == RF_ROL) r[0] = cf;
         if (rf == RF_ROR) r[w-1] = cf;
         if (rf == RF_SAR) r[w-1] = top;
      end
      if (n != 0) begin
         fo[F_CF] = cf;
         if (n == 1) begin
            fo[F_OF] = (rf == RF_ROL || rf == RF_SHL) ? (r[w-1] ^ cf) : (r[w-1] ^ r[w-2]);
         end else if (rf == RF_SAR) begin
            fo[F_OF] = 1'b0;
         end
         if (rf == RF_SHL || rf == RF_SAR) begin
            fo[F_PF] = ~^r[7:0];
            fo[F_SF] = r[w-1];
            fo[F_ZF] = (r == 16'h0000);
         end
      end
      return {fo, r};
   endfunction : shift_ref

   // Subtract with borrow: returns {flags, result}
   function automatic logic [31:0] sbb_ref(input logic wide, input logic [15:0] a, input logic [15:0] b,
                                           input logic [15:0] f);
      logic [16:0] d;
      logic [15:0] r, m, fo;
      int          w;
      w  = wide ? 16 : 8;
      m  = wide ? 16'hFFFF : 16'h00FF;
      d  = {1'b0, a & m} - {1'b0, b & m} - {16'h0000, f[F_CF]};
      r  = d[15:0] & m;
      fo = f;
      fo[F_CF] = d[w];
      fo[F_AF] = a[4] ^ b[4] ^ r[4];
      fo[F_OF] = (a[w-1] ^ b[w-1]) & (a[w-1] ^ r[w-1]);
      fo[F_PF] = ~^r[7:0];
      fo[F_SF] = r[w-1];
      fo[F_ZF] = (r == 16'h0000);
      return {fo, r};
   endfunction : sbb_ref

   // ----------------------------------------
   // Watchdog and main sequence
   // ----------------------------------------
   initial begin
      repeat (40000) @(posedge aclk);
      err_count++;
      report_and_stop();
   end

   initial begin
      logic [7:0]  ret_ops [4] = '{OPC_RN, OPC_RNI, OPC_RF, OPC_RFI};
      logic [2:0]  rf_tab  [4] = '{RF_ROL, RF_ROR, RF_SHL, RF_SAR};
      logic [15:0] sp, s0, s1, im, fl, a, b, exp_sp;
      logic [7:0]  opc, cnt;
      logic [2:0]  rf;
      logic [31:0] e;
      void'($urandom(88189));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // Returns, every form twice, stack words staged first
      for (int k = 0; k < 8; k++) begin
         opc = ret_ops[k % 4];
         sp  = 16'($urandom);
         s0  = 16'($urandom);
         s1  = 16'($urandom);
         im  = 16'($urandom);
         fl  = 16'($urandom) & FMSK;
         wr(ADR_SP, {16'h0000, sp});
         wr(ADR_STK0, {16'h0000, s0});
         wr(ADR_STK1, {16'h0000, s1});
         wr(ADR_IMM, {16'h0000, im});
         wr(ADR_FLG, {16'h0000, fl});
         wr(ADR_CMD, {24'h00_0000, opc});
         exp_sp = sp + (opc[3] ? 16'h0004 : SP_STEP) + (opc[0] ? 16'h0000 : im);
         rd(ADR_IP);
         `check_eq(rd_data, {16'h0000, s0})
         rd(ADR_SP);
         `check_eq(rd_data, {16'h0000, exp_sp})
         rd(ADR_CS);
         if (opc[3]) `check_eq(rd_data, {16'h0000, s1})
         rd(ADR_FLG);
         `check_eq(rd_data, {16'h0000, fl})
      end
      // Shift and rotate group, random with corner cases first
      for (int k = 0; k < 48; k++) begin
         rf  = rf_tab[$urandom_range(3)];
         opc = {OPC_SHG, 2'($urandom_range(3))};
         a   = 16'($urandom);
         cnt = (rf == RF_ROL || rf == RF_ROR) ? 8'($urandom_range(opc[0] ? 15 : 7, 1)) : 8'($urandom_range(20));
         if (k == 0) begin
            opc = 8'hD0;
            cnt = 8'h05;
         end
         if (k == 1) begin
            rf  = RF_SAR;
            opc = 8'hD3;
            a   = 16'h8005;
            cnt = 8'h10;
         end
         fl = 16'($urandom) & FMSK;
         wr(ADR_OPA, {16'h0000, a});
         wr(ADR_CNT, {24'h00_0000, cnt});
         wr(ADR_FLG, {16'h0000, fl});
         wr(ADR_CMD, {21'h00_0000, rf, opc});
         e = shift_ref(opc, rf, a, cnt, fl);
         rd(ADR_RES);
         `check_eq(rd_data, {16'h0000, e[15:0]})
         rd(ADR_FLG);
         `check_eq(rd_data, {16'h0000, e[31:16]})
      end
      // Flag load from accumulator high byte
      for (int k = 0; k < 6; k++) begin
         a  = {8'h00, 8'($urandom)};
         fl = 16'($urandom) & FMSK;
         wr(ADR_ACCH, {16'h0000, a});
         wr(ADR_FLG, {16'h0000, fl});
         wr(ADR_CMD, {24'h00_0000, OPC_FLD});
         rd(ADR_FLG);
         `check_eq(rd_data, {16'h0000, (fl & ~LOAD_MSK) | (a & LOAD_MSK)})
      end
      // Subtract with borrow, byte and word, equal operands with borrow first
      for (int k = 0; k < 24; k++) begin
         a  = 16'($urandom);
         b  = (k == 0) ? a : 16'($urandom);
         fl = (k == 0) ? 16'h0001 : (16'($urandom) & FMSK);
         wr(ADR_OPA, {16'h0000, a});
         wr(ADR_OPB, {16'h0000, b});
         wr(ADR_FLG, {16'h0000, fl});
         wr(ADR_CMD, {14'h0000, 1'b1, k[0], 16'h0000});
         e = sbb_ref(k[0], a, b, fl);
         rd(ADR_RES);
         `check_eq(rd_data, {16'h0000, e[15:0]})
         rd(ADR_FLG);
         `check_eq(rd_data, {16'h0000, e[31:16]})
      end
      // Unsupported shift field is flagged, a good command clears it again
      wr(ADR_CMD, {21'h00_0000, 3'h2, 8'hD1});
      rd(ADR_STAT);
      `check_eq(rd_data, 32'h0000_0001)
      wr(ADR_CMD, {24'h00_0000, OPC_FLD});
      rd(ADR_STAT);
      `check_eq(rd_data, 32'h0000_0000)
      // Unmapped read and read-only write are refused
      rd(8'h40);
      `check_eq({rd_resp, rd_data}, {RESP_ERR, 32'h0000_0000})
      wr(ADR_RES, 32'h0000_1234);
      `check_eq(wr_resp, RESP_ERR)
      report_and_stop();
   end
endmodule : testbench
